//--- verilog/nmcg_cfg.svh
// constants for the native mode configuration gate
`ifndef NMCG_CFG_SVH
`define NMCG_CFG_SVH
`define NMCG_ADDR_COMPAT 32'hFFFE100C
`define NMCG_ADDR_PFS9 32'hFFFE1024
`define NMCG_ADDR_STATUS 32'hFFFE1028
`define NMCG_NATIVE_KEY 32'h0000EAEF
`define NMCG_RESET_VAL 32'h00000000
`define NMCG_TX_HI 23
`define NMCG_TX_LO 21
`define NMCG_RTS_HI 14
`define NMCG_RTS_LO 12
`define NMCG_SEL_SERIAL1 3'h1
`endif

//--- verilog/nmcg_pkg.sv
// types for the native mode configuration gate
package nmcg_pkg;
  typedef enum logic [1:0] {
    NMCG_COMPAT = 2'h1,
    NMCG_NATIVE = 2'h2
  } nmcg_mode_e;
endpackage

//--- verilog/nmcg_gate.sv
// native mode gate and holding logic for configuration registers
// Operation
// - after reset the effective configuration is the legacy all-off one.
// - writing key 0x0000EAEF to the compat control word enters native mode.
// - in native mode the configuration registers take full effect.
// - reset clears every configuration register to zero.
// - fields [23:21] and [14:12] equal to 001 route serial port 1 tx/rts.
`timescale 1ns/1ps
`include "nmcg_cfg.svh"
module nmcg_gate
  import nmcg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic native_mode,
  output logic [31:0] pin_function_select_9_eff,
  output logic serial_port1_transmit_en,
  output logic serial_port1_request_to_send_en
);
  nmcg_mode_e mode_q;
  logic [31:0] compat_q;
  logic [31:0] pfs9_q;
  logic [31:0] pfs9_eff_q;
  logic [31:0] rdata_q;
  logic key_hit;

  assign key_hit = wr && (addr == `NMCG_ADDR_COMPAT)
    && (wdata == `NMCG_NATIVE_KEY);

  // mode state; only reset leaves native mode, as on the real part
  // key enters native
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      mode_q <= NMCG_COMPAT;
    else
    begin
      case (mode_q)
        NMCG_COMPAT:
          if (key_hit)
            mode_q <= NMCG_NATIVE;
        NMCG_NATIVE:
          mode_q <= NMCG_NATIVE;
        default:
          mode_q <= NMCG_COMPAT;
      endcase
    end
  end

  // software-visible holding registers
  // clear on reset
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      compat_q <= `NMCG_RESET_VAL;
      pfs9_q <= `NMCG_RESET_VAL;
    end
    else if (wr)
    begin
      if (addr == `NMCG_ADDR_COMPAT)
        compat_q <= wdata;
      if (addr == `NMCG_ADDR_PFS9)
        pfs9_q <= wdata;
    end
  end

  // effective copy drives the pins; held at zero until native mode
  // so a half-written set never reaches the balls
  // legacy until key
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      pfs9_eff_q <= `NMCG_RESET_VAL;
    else if (key_hit && mode_q == NMCG_COMPAT)
      pfs9_eff_q <= (wr && addr == `NMCG_ADDR_PFS9) ? wdata : pfs9_q;
    else if (mode_q == NMCG_NATIVE)
      pfs9_eff_q <= (wr && addr == `NMCG_ADDR_PFS9) ? wdata : pfs9_q;
  end

  // read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      rdata_q <= `NMCG_RESET_VAL;
    else if (rd)
    begin
      case (addr)
        `NMCG_ADDR_COMPAT: rdata_q <= compat_q;
        `NMCG_ADDR_PFS9: rdata_q <= pfs9_q;
        `NMCG_ADDR_STATUS: rdata_q <= {31'h0, mode_q == NMCG_NATIVE};
        default: rdata_q <= `NMCG_RESET_VAL;
      endcase
    end
    else
      rdata_q <= `NMCG_RESET_VAL;
  end

  assign rdata = rdata_q;
  assign native_mode = (mode_q == NMCG_NATIVE);
  assign pin_function_select_9_eff = pfs9_eff_q;
  assign serial_port1_transmit_en =
    pfs9_eff_q[`NMCG_TX_HI:`NMCG_TX_LO] == `NMCG_SEL_SERIAL1;
  assign serial_port1_request_to_send_en =
    pfs9_eff_q[`NMCG_RTS_HI:`NMCG_RTS_LO] == `NMCG_SEL_SERIAL1;

  // decode helpers for the checks below; they are written apart from
  // the datapath so a slip in its address compare is not mirrored here
  logic wr_pfs9;
  logic wr_compat;
  logic rd_compat;
  logic rd_pfs9;
  logic rd_status;
  logic [`NMCG_TX_HI-`NMCG_TX_LO:0] tx_field;
  logic [`NMCG_RTS_HI-`NMCG_RTS_LO:0] rts_field;

  // plain address matches and field slices
  assign wr_pfs9 = wr && (addr == `NMCG_ADDR_PFS9);
  assign wr_compat = wr && (addr == `NMCG_ADDR_COMPAT);
  assign rd_compat = rd && (addr == `NMCG_ADDR_COMPAT);
  assign rd_pfs9 = rd && (addr == `NMCG_ADDR_PFS9);
  assign rd_status = rd && (addr == `NMCG_ADDR_STATUS);
  assign tx_field = pfs9_eff_q[`NMCG_TX_HI:`NMCG_TX_LO];
  assign rts_field = pfs9_eff_q[`NMCG_RTS_HI:`NMCG_RTS_LO];

  // the key write reaches native mode on the very next edge; software
  // may read status right after it
  key_enters_native_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    key_hit
    |=> native_mode)
    else $error("key did not enter native mode");

  // only the exact key leaves compat mode; a near miss just lands in
  // the compat word
  compat_stays_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    !native_mode && !key_hit
    |=> !native_mode)
    else $error("left compat mode without the key");

  // native mode is sticky; there is no way back in software
  // short of a reset
  native_sticky_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    native_mode
    |=> native_mode)
    else $error("native mode dropped");

  // the state register only ever holds one of its two one-hot codes
  // (a stray code would be pulled back to compat by the default branch)
  mode_legal_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (mode_q == NMCG_COMPAT) ||
    (mode_q == NMCG_NATIVE))
    else $error("mode register holds an illegal code");

  // nothing reaches the pins before native mode, however much has been
  // written to the holding registers
  compat_pins_off_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    !native_mode
    |-> pfs9_eff_q == `NMCG_RESET_VAL)
    else $error("effective config leaked in compat mode");

  // neither serial port function is routed while still in compat mode
  // (the legacy ball functions stay in place)
  routes_off_compat_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    !native_mode
    |-> !serial_port1_transmit_en && !serial_port1_request_to_send_en)
    else $error("serial port routed in compat mode");

  // any write to the compat word is stored as written, key or not,
  // so software can read back what it wrote
  compat_write_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    wr_compat
    |=> compat_q == $past(wdata))
    else $error("compat word write lost");

  // the compat word only moves on its own write
  // (reset is masked by the disable clause)
  compat_hold_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    !wr_compat
    |=> $stable(compat_q))
    else $error("compat word changed without a write");

  // a write to the select register is held in the holding copy
  // whatever the mode
  pfs9_write_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    wr_pfs9
    |=> pfs9_q == $past(wdata))
    else $error("select register write lost");

  // the holding copy keeps its value between writes, so a setting
  // made early in compat mode is still there when the key arrives
  pfs9_hold_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    !wr_pfs9
    |=> $stable(pfs9_q))
    else $error("held select value changed without a write");

  // at the key the held value goes to the pins in one step; the whole
  // set switches together
  held_applied_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    key_hit && !native_mode
    |=> pfs9_eff_q == $past(pfs9_q))
    else $error("held value not applied at key");

  // once native, the pins follow the register one cycle behind, or the
  // word just written when a write lands on the select register
  native_tracks_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    native_mode ##1 native_mode
    |-> pfs9_eff_q == ($past(wr_pfs9) ? $past(wdata) : $past(pfs9_q)))
    else $error("native mode does not track register");

  // in native mode a new select word reaches the pins on the next edge
  // with no extra key write
  native_write_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    native_mode && wr_pfs9
    |=> pfs9_eff_q == $past(wdata))
    else $error("native write did not reach the pins");

  // a second key write in native mode changes nothing at the pins
  // (the key is harmless to repeat)
  native_rekey_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    native_mode && key_hit
    |=> pfs9_eff_q == $past(pfs9_q))
    else $error("repeated key disturbed the pins");

  // reset clears every configuration register and leaves native mode
  // (checked on the edge after each reset cycle)
  reset_clears_a: assert property (
    @(posedge ref_clk)
    $past(srst)
    |-> compat_q == `NMCG_RESET_VAL && pfs9_q == `NMCG_RESET_VAL &&
      !native_mode)
    else $error("reset did not clear configuration");

  // the applied copy and the read port come out of reset at zero too,
  // so no routing is left over from before the reset
  reset_pins_off_a: assert property (
    @(posedge ref_clk)
    $past(srst)
    |-> pfs9_eff_q == `NMCG_RESET_VAL && rdata == `NMCG_RESET_VAL)
    else $error("outputs not cleared by reset");

  // transmit is routed exactly when its field holds the serial code
  // checked against the helper slice, not the output expression
  tx_route_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    serial_port1_transmit_en == (tx_field == `NMCG_SEL_SERIAL1))
    else $error("transmit routing wrong");

  // request-to-send likewise, from its own field
  rts_route_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    serial_port1_request_to_send_en == (rts_field == `NMCG_SEL_SERIAL1))
    else $error("rts routing wrong");

  // reads return the holding copies one cycle after the strobe
  read_compat_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    rd_compat
    |=> rdata == $past(compat_q))
    else $error("compat read data wrong");

  // the held select word reads back even before native mode
  read_pfs9_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    rd_pfs9
    |=> rdata == $past(pfs9_q))
    else $error("select read data wrong");

  // the status word shows native mode in bit zero, all else zero
  read_status_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    rd_status
    |=> rdata == {31'h0, $past(native_mode)})
    else $error("status read data wrong");

  // read data stands for one cycle only; with no read it is zero
  // so a stale word cannot be mistaken for a fresh answer
  read_idle_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    !rd
    |=> rdata == `NMCG_RESET_VAL)
    else $error("read data not cleared after the read");
endmodule

//--- verification/test_native_mode_config_gate.sv
// bench for the native mode configuration gate
`timescale 1ns/1ps
`include "nmcg_cfg.svh"
module test_native_mode_config_gate;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, eff;
  logic nat, tx, rts;
  int fails = 0;
  int comparisons = 0;
  nmcg_gate uut (.ref_clk(ref_clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .native_mode(nat),
    .pin_function_select_9_eff(eff), .serial_port1_transmit_en(tx),
    .serial_port1_request_to_send_en(rts));
  // 100 ns clock
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // one-cycle strobes launched at a rising edge; checks wait 1 ns past
  // the taking edge so the registered outputs have settled
  task automatic bwr(logic [31:0] a, logic [31:0] d);
    @(posedge ref_clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'h0;
    #1;
  endtask
  task automatic brd(string n, logic [31:0] a, logic [31:0] e);
    @(posedge ref_clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'h0;
    #1;
    chk(n, e, rdata);
    // read data stands one cycle only, then drops back to zero
    @(posedge ref_clk);
    #1;
    chk({n, "_idle"}, 32'h0, rdata);
  endtask
  task automatic outs(logic [31:0] e, logic n, logic t, logic r);
    chk("eff", e, eff);
    chk("native", {31'h0, n}, {31'h0, nat});
    chk("tx_en", {31'h0, t}, {31'h0, tx});
    chk("rts_en", {31'h0, r}, {31'h0, rts});
  endtask
  task automatic reset_state;
    outs(32'h0, 1'h0, 1'h0, 1'h0);
    brd("compat", `NMCG_ADDR_COMPAT, 32'h0);
    brd("pfs9", `NMCG_ADDR_PFS9, 32'h0);
    brd("status", `NMCG_ADDR_STATUS, 32'h0);
  endtask
  // settings first, a near-miss key, then the real key
  task automatic hold_then_key;
    bwr(`NMCG_ADDR_PFS9, 32'h00201000);
    outs(32'h0, 1'h0, 1'h0, 1'h0);
    bwr(`NMCG_ADDR_COMPAT, 32'h0000EAEE);
    outs(32'h0, 1'h0, 1'h0, 1'h0);
    brd("compat", `NMCG_ADDR_COMPAT, 32'h0000EAEE);
    bwr(`NMCG_ADDR_COMPAT, `NMCG_NATIVE_KEY);
    outs(32'h00201000, 1'h1, 1'h1, 1'h1);
    brd("status", `NMCG_ADDR_STATUS, 32'h1);
  endtask
  // field boundaries: only 001 routes the serial port
  task automatic native_fields;
    bwr(`NMCG_ADDR_PFS9, 32'h00600000);
    outs(32'h00600000, 1'h1, 1'h0, 1'h0);
    bwr(`NMCG_ADDR_PFS9, 32'h00203000);
    outs(32'h00203000, 1'h1, 1'h1, 1'h0);
    brd("unmapped", 32'hFFFE2000, 32'h0);
  endtask
  // mid-run reset, raised and dropped at rising edges
  task automatic reset_again;
    @(posedge ref_clk);
    srst <= 1'h1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'h0;
    #1;
    reset_state();
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog: the tests need well under 100 cycles
  initial
  begin
    #100000;
    fails++;
    tally_and_finish();
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'h0;
    #1;
    reset_state();
    hold_then_key();
    native_fields();
    reset_again();
    tally_and_finish();
  end
endmodule
